/* asr_pkg.sv */
// Constants, timing figures and state type for the asynchronous SRAM controller.
// Assumes a single 250 MHz system clock; every pin time is converted to cycles here.
package asr_pkg;
    localparam int CLK_MHZ = 250;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam int LANES = 2;
    localparam int CNT_W = 8;
    localparam int SYNC_LAT = 3;
    localparam int SYNC_STAGES = 3;

    // Pin timing in ns for the two speed grades.
    localparam int SPEED_FAST = 55;
    localparam int SPEED_SLOW = 70;
    localparam int T_WP_FAST_NS = 40;
    localparam int T_WP_SLOW_NS = 50;
    localparam int T_AA_FAST_NS = 55;
    localparam int T_AA_SLOW_NS = 70;
    localparam int T_READ_CYC_FAST_NS = 55;
    localparam int T_READ_CYC_SLOW_NS = 70;
    localparam int T_CW_FAST_NS = 45;
    localparam int T_CW_SLOW_NS = 60;
    localparam int T_OHZ_FAST_NS = 20;
    localparam int T_OHZ_SLOW_NS = 25;

    // Least times round up to whole cycles, never below one.
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max_int(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    typedef enum logic [2:0] {
        ST_RECOVER,
        ST_RETAIN,
        ST_IDLE,
        ST_READ,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_HOLD,
        ST_GAP
    } asr_state_t;
endpackage

/* asr_pin_sync.sv */
// Three-stage input synchroniser for signals arriving from device pins.
// The output changes only once the second and third stages agree.
`timescale 1ns/1ps
module asr_pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Pin side
    input wire logic [WIDTH-1:0] pin_in,
    // Clock domain side
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    always_comb
    begin
        q_nxt = q_r;
        if (s2_r == s3_r)
        begin
            q_nxt = s3_r;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign sync_out = q_r;
endmodule

/* asr_sram_ctrl.sv */
// Host-side controller that drives a 256k x 16 asynchronous SRAM through its pins.
// Assumes the SRAM is the only driver of the data lines besides this block.
//
// Function
// - Access needs primary select low, secondary high.
// - Hold write active at least pulse width.
// - Wait full access time before sampling data.
// - Wait one read cycle after retention.
`timescale 1ns/1ps
module asr_sram_ctrl #(
    parameter int SPEED_GRADE = 55
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // User request port
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [asr_pkg::ADDR_W-1:0] req_addr,
    input wire logic [asr_pkg::DATA_W-1:0] req_wdata,
    input wire logic [asr_pkg::LANES-1:0] req_lane_en,
    // Read answer
    output logic rsp_valid,
    output logic [asr_pkg::DATA_W-1:0] rsp_rdata,
    // Supply retention indication, high while the SRAM supply is low
    input wire logic supply_retention,
    // SRAM pins
    output logic [asr_pkg::ADDR_W-1:0] word_select_lines,
    output logic chip_select_primary_n,
    output logic chip_select_secondary,
    output logic write_strobe_n,
    output logic output_gate_n,
    output logic lower_lane_select_n,
    output logic upper_lane_select_n,
    input wire logic [asr_pkg::DATA_W-1:0] data_lines_in,
    output logic [asr_pkg::DATA_W-1:0] data_lines_out,
    output logic data_lines_drive_n
);
    localparam bit FAST = (SPEED_GRADE == asr_pkg::SPEED_FAST);
    localparam int WP_CYC = asr_pkg::ns_to_cyc(
        FAST ? asr_pkg::T_WP_FAST_NS : asr_pkg::T_WP_SLOW_NS);
    localparam int CW_CYC = asr_pkg::ns_to_cyc(
        FAST ? asr_pkg::T_CW_FAST_NS : asr_pkg::T_CW_SLOW_NS);
    localparam int RD_CYC = asr_pkg::ns_to_cyc(
        FAST ? asr_pkg::T_AA_FAST_NS : asr_pkg::T_AA_SLOW_NS);
    localparam int RC_CYC = asr_pkg::ns_to_cyc(
        FAST ? asr_pkg::T_READ_CYC_FAST_NS : asr_pkg::T_READ_CYC_SLOW_NS);
    localparam int OHZ_CYC = asr_pkg::ns_to_cyc(
        FAST ? asr_pkg::T_OHZ_FAST_NS : asr_pkg::T_OHZ_SLOW_NS);
    // Strobe stays low long enough for both the pulse width and select-to-end figures.
    localparam int PULSE_CYC = asr_pkg::max_int(WP_CYC, CW_CYC);
    // Gap after a write pads the whole cycle to at least the read cycle time.
    localparam int WR_GAP_CYC = asr_pkg::max_int(1, RC_CYC - PULSE_CYC - 2);
    // Gap after a read lets the SRAM outputs float before the next write drives the bus.
    localparam int RD_GAP_CYC = OHZ_CYC;
    localparam int RD_WAIT = RD_CYC + asr_pkg::SYNC_LAT;
    // The answer is registered on the edge after the count reaches zero, so it is seen two past the wait.
    localparam int A_RD_LAT = RD_WAIT + 2;

    if (SPEED_GRADE != asr_pkg::SPEED_FAST && SPEED_GRADE != asr_pkg::SPEED_SLOW)
    begin : g_bad_speed
        $error("SPEED_GRADE must be 55 or 70");
    end
    if (asr_pkg::DATA_W != asr_pkg::LANES * asr_pkg::LANE_W)
    begin : g_bad_width
        $error("data width must be two byte lanes");
    end

    logic ret_sync;
    logic [asr_pkg::DATA_W-1:0] data_sync;

    asr_pin_sync #(.WIDTH(1)) u_ret_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in(supply_retention),
        .sync_out(ret_sync)
    );

    // Read data also crosses from the pins; its latency is folded into the read wait.
    asr_pin_sync #(.WIDTH(asr_pkg::DATA_W)) u_data_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in(data_lines_in),
        .sync_out(data_sync)
    );

    asr_pkg::asr_state_t state_r, state_nxt;
    logic [asr_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [asr_pkg::ADDR_W-1:0] addr_r, addr_nxt;
    logic [asr_pkg::DATA_W-1:0] wdata_r, wdata_nxt;
    logic [asr_pkg::LANES-1:0] lane_r, lane_nxt;
    logic cs_r, cs_nxt;
    logic we_n_r, we_n_nxt;
    logic gate_n_r, gate_n_nxt;
    logic drive_n_r, drive_n_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic [asr_pkg::DATA_W-1:0] rdata_r, rdata_nxt;

    assign req_ready = (state_r == asr_pkg::ST_IDLE) && !ret_sync;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        lane_nxt = lane_r;
        cs_nxt = cs_r;
        we_n_nxt = we_n_r;
        gate_n_nxt = gate_n_r;
        drive_n_nxt = drive_n_r;
        rsp_valid_nxt = 1'b0;
        rdata_nxt = rdata_r;
        unique case (state_r)
            asr_pkg::ST_RECOVER:
            begin
                if (ret_sync)
                begin
                    state_nxt = asr_pkg::ST_RETAIN;
                end
                else if (cnt_r == '0)
                begin
                    state_nxt = asr_pkg::ST_IDLE;
                end
                else
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            asr_pkg::ST_RETAIN:
            begin
                if (!ret_sync)
                begin
                    state_nxt = asr_pkg::ST_RECOVER;
                    cnt_nxt = asr_pkg::CNT_W'(RC_CYC - 1);
                end
            end
            asr_pkg::ST_IDLE:
            begin
                if (ret_sync)
                begin
                    state_nxt = asr_pkg::ST_RETAIN;
                end
                else if (req_valid)
                begin
                    addr_nxt = req_addr;
                    lane_nxt = req_lane_en;
                    cs_nxt = 1'b1;
                    if (req_write)
                    begin
                        wdata_nxt = req_wdata;
                        drive_n_nxt = 1'b0;
                        state_nxt = asr_pkg::ST_WR_SETUP;
                    end
                    else
                    begin
                        gate_n_nxt = 1'b0;
                        cnt_nxt = asr_pkg::CNT_W'(RD_WAIT);
                        state_nxt = asr_pkg::ST_READ;
                    end
                end
            end
            asr_pkg::ST_READ:
            begin
                if (cnt_r == '0)
                begin
                    // Lanes that were not selected return zero, not floating data.
                    rdata_nxt[7:0] = lane_r[0] ? data_sync[7:0] : 8'h00;
                    rdata_nxt[15:8] = lane_r[1] ? data_sync[15:8] : 8'h00;
                    rsp_valid_nxt = 1'b1;
                    cs_nxt = 1'b0;
                    gate_n_nxt = 1'b1;
                    lane_nxt = '0;
                    cnt_nxt = asr_pkg::CNT_W'(RD_GAP_CYC - 1);
                    state_nxt = asr_pkg::ST_GAP;
                end
                else
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            asr_pkg::ST_WR_SETUP:
            begin
                we_n_nxt = 1'b0;
                cnt_nxt = asr_pkg::CNT_W'(PULSE_CYC - 1);
                state_nxt = asr_pkg::ST_WR_PULSE;
            end
            asr_pkg::ST_WR_PULSE:
            begin
                if (cnt_r == '0)
                begin
                    // Strobe rises first so the write ends with data still held.
                    we_n_nxt = 1'b1;
                    state_nxt = asr_pkg::ST_WR_HOLD;
                end
                else
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            asr_pkg::ST_WR_HOLD:
            begin
                cs_nxt = 1'b0;
                drive_n_nxt = 1'b1;
                lane_nxt = '0;
                cnt_nxt = asr_pkg::CNT_W'(WR_GAP_CYC - 1);
                state_nxt = asr_pkg::ST_GAP;
            end
            asr_pkg::ST_GAP:
            begin
                if (cnt_r == '0)
                begin
                    state_nxt = asr_pkg::ST_IDLE;
                end
                else
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= asr_pkg::ST_RECOVER;
            cnt_r <= asr_pkg::CNT_W'(RC_CYC - 1);
            addr_r <= '0;
            wdata_r <= '0;
            lane_r <= '0;
            cs_r <= 1'b0;
            we_n_r <= 1'b1;
            gate_n_r <= 1'b1;
            drive_n_r <= 1'b1;
            rsp_valid_r <= 1'b0;
            rdata_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            lane_r <= lane_nxt;
            cs_r <= cs_nxt;
            we_n_r <= we_n_nxt;
            gate_n_r <= gate_n_nxt;
            drive_n_r <= drive_n_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Both selects move together so a half-selected SRAM is never seen.
    assign chip_select_primary_n = !cs_r;
    assign chip_select_secondary = cs_r;
    assign word_select_lines = addr_r;
    assign write_strobe_n = we_n_r;
    assign output_gate_n = gate_n_r;
    assign lower_lane_select_n = !lane_r[0];
    assign upper_lane_select_n = !lane_r[1];
    assign data_lines_out = wdata_r;
    assign data_lines_drive_n = drive_n_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_rdata = rdata_r;

    // Helper counters read only by the checks below.
    logic [asr_pkg::CNT_W-1:0] we_low_cnt, gate_low_cnt, free_cnt;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            we_low_cnt <= '0;
            gate_low_cnt <= '0;
            free_cnt <= '0;
        end
        else
        begin
            we_low_cnt <= write_strobe_n ? '0 : we_low_cnt + 1'b1;
            gate_low_cnt <= output_gate_n ? '0 : gate_low_cnt + 1'b1;
            free_cnt <= ret_sync ? '0 : ((&free_cnt) ? free_cnt : free_cnt + 1'b1);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_wr_accept;
        req_valid && req_ready && req_write;
    endsequence
    sequence s_rd_accept;
        req_valid && req_ready && !req_write;
    endsequence
    sequence s_wr_start;
        (!chip_select_primary_n && write_strobe_n && !data_lines_drive_n) ##1 !write_strobe_n;
    endsequence

    a_select_pair_access: assert property ((!write_strobe_n || !output_gate_n) |->
        (!chip_select_primary_n && chip_select_secondary))
        else $error("access without both chip selects active");
    a_write_pulse_width: assert property ($rose(write_strobe_n) |-> we_low_cnt >= WP_CYC)
        else $error("write strobe pulse too short");
    a_read_access_wait: assert property (rsp_valid |-> gate_low_cnt >= RD_CYC)
        else $error("read data sampled before access time");
    a_read_latency_exact: assert property (s_rd_accept |-> ##A_RD_LAT rsp_valid)
        else $error("read answer not at expected cycle");
    a_recover_before_use: assert property (req_ready |-> free_cnt >= RC_CYC)
        else $error("access offered too soon after retention");
    a_write_sequence: assert property (s_wr_accept |=> s_wr_start)
        else $error("write did not start with setup then strobe");
    a_no_drive_on_read: assert property (!output_gate_n |-> data_lines_drive_n)
        else $error("controller drives data lines during read");
    a_retain_deselect: assert property (ret_sync && state_r == asr_pkg::ST_RETAIN |->
        chip_select_primary_n && !chip_select_secondary)
        else $error("sram selected during retention");
endmodule

/* asr_sram_model.sv */
// Behavioural 256k x 16 asynchronous SRAM standing on the controller's pins.
// Assumes the bench resolves the shared data lines and feeds the wire level back as dq_in.
`timescale 1ns/1ps
module asr_sram_model #(
    parameter int T_ACC = 55,
    parameter int T_WP = 40,
    parameter int T_READ_CYC = 55
) (
    // Device pins
    input wire logic [17:0] word_select_lines,
    input wire logic chip_select_primary_n,
    input wire logic chip_select_secondary,
    input wire logic write_strobe_n,
    input wire logic output_gate_n,
    input wire logic lower_lane_select_n,
    input wire logic upper_lane_select_n,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic [1:0] lane_oe_n,
    // Controller drive enable, supply state and fault flag
    input wire logic ctrl_drive_n,
    input wire logic supply_low,
    output logic rule_err
);
    logic [15:0] mem [int];
    logic [15:0] word;
    logic [15:0] nw;
    logic sel;
    logic wr_act;
    realtime t_chg = 0.0;
    realtime t_wr = 0.0;
    realtime t_up = -1000.0;

    initial
        rule_err = 1'h0;
    assign sel = !chip_select_primary_n && chip_select_secondary;
    assign wr_act = sel && !write_strobe_n;
    assign lane_oe_n[0] = !(sel && write_strobe_n && !output_gate_n && !lower_lane_select_n);
    assign lane_oe_n[1] = !(sel && write_strobe_n && !output_gate_n && !upper_lane_select_n);

    always @(word_select_lines, sel, output_gate_n, lower_lane_select_n, upper_lane_select_n)
        t_chg = $realtime;

    // Until the access time has run the lanes carry the inverse word, so early sampling shows.
    always #1
    begin
        word = mem.exists(int'(word_select_lines)) ? mem[int'(word_select_lines)] : 16'h0000;
        dq_out = ($realtime - t_chg >= T_ACC) ? word : ~word;
    end

    always @(posedge wr_act)
        t_wr = $realtime;

    always @(negedge wr_act)
    begin
        nw = mem.exists(int'(word_select_lines)) ? mem[int'(word_select_lines)] : 16'h0000;
        if (!lower_lane_select_n)
            nw[7:0] = dq_in[7:0];
        if (!upper_lane_select_n)
            nw[15:8] = dq_in[15:8];
        mem[int'(word_select_lines)] = nw;
        if ($realtime - t_wr < T_WP)
            rule_err = 1'h1;
    end

    always @*
        if (!ctrl_drive_n && lane_oe_n !== 2'h3)
            rule_err = 1'h1;

    always @(negedge supply_low)
        t_up = $realtime;

    always @(posedge sel)
        if (supply_low || $realtime - t_up < T_READ_CYC)
            rule_err = 1'h1;
endmodule

/* asr_sram_ctrl_bench.sv */
// Self-checking bench: the controller drives a behavioural SRAM through its pins.
// Assumes the 55 ns grade and a 250 MHz clock.
`timescale 1ns/1ps
module asr_sram_ctrl_bench;
    typedef struct {
        logic wr;
        logic [17:0] a;
        logic [15:0] d;
        logic [1:0] ln;
        logic [15:0] exp;
    } asr_row_t;
    localparam int RC_CYC = (asr_pkg::T_READ_CYC_FAST_NS * asr_pkg::CLK_MHZ + 999) / 1000;
    // Answer counted in falling edges after the accept edge, synchroniser included.
    localparam int RD_LAT = (asr_pkg::T_AA_FAST_NS * asr_pkg::CLK_MHZ + 999) / 1000 + 5;
    logic sys_clk, rst, req_valid, req_ready, req_write, rsp_valid, supply_retention;
    logic [17:0] req_addr, word_select_lines;
    logic [15:0] req_wdata, rsp_rdata, data_lines_in, data_lines_out, dq_model;
    logic [15:0] float_pat = 16'h5a5a;
    logic [1:0] req_lane_en, lane_oe_n;
    logic chip_select_primary_n, chip_select_secondary, write_strobe_n, output_gate_n;
    logic lower_lane_select_n, upper_lane_select_n, data_lines_drive_n, rule_err;
    int failures = 0;
    int n_checks = 0;
    asr_row_t rows [15];

    asr_sram_ctrl #(.SPEED_GRADE(55)) u_asr_sram_ctrl (
        .sys_clk, .rst, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata,
        .req_lane_en, .rsp_valid, .rsp_rdata, .supply_retention, .word_select_lines,
        .chip_select_primary_n, .chip_select_secondary, .write_strobe_n, .output_gate_n,
        .lower_lane_select_n, .upper_lane_select_n, .data_lines_in, .data_lines_out,
        .data_lines_drive_n
    );
    asr_sram_model #(.T_ACC(55), .T_WP(40), .T_READ_CYC(55)) u_asr_sram_model (
        .word_select_lines, .chip_select_primary_n, .chip_select_secondary, .write_strobe_n,
        .output_gate_n, .lower_lane_select_n, .upper_lane_select_n, .dq_in(data_lines_in),
        .dq_out(dq_model), .lane_oe_n, .ctrl_drive_n(data_lines_drive_n),
        .supply_low(supply_retention), .rule_err
    );

    // No pull on the data lines: an undriven bit shows a pattern that flips every cycle.
    always_comb
        for (int i = 0; i < 16; i++)
            data_lines_in[i] = !data_lines_drive_n ? data_lines_out[i] :
                !lane_oe_n[i / 8] ? dq_model[i] : float_pat[i];
    always @(posedge sys_clk)
        float_pat <= ~float_pat;

    initial
    begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic give_verdict();
        $display("Checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: data %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_count(input int got, input int exp);
        n_checks++;
        if (got != exp)
        begin
            failures++;
            $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask

    task automatic wait_ready(output int n);
        n = 0;
        while (req_ready !== 1'h1 && n < 500)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (req_ready !== 1'h1)
        begin
            failures++;
            $display("Error at %0t: wait ran out", $time);
            give_verdict();
        end
    endtask

    task automatic send(input logic wr, input logic [17:0] a, input logic [15:0] d,
        input logic [1:0] ln);
        int n;
        req_valid = 1'h1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_lane_en = ln;
        wait_ready(n);
        @(negedge sys_clk);
        req_valid = 1'h0;
    endtask

    task automatic do_req(input logic wr, input logic [17:0] a, input logic [15:0] d,
        input logic [1:0] ln, input logic [15:0] exp);
        int n;
        send(wr, a, d, ln);
        n = 1;
        while (wr === 1'h0 && rsp_valid !== 1'h1 && n < 100)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (wr === 1'h0 && rsp_valid !== 1'h1)
        begin
            failures++;
            $display("Error at %0t: read answer wait ran out", $time);
            give_verdict();
        end
        if (wr === 1'h0)
        begin
            chk_count(n, RD_LAT);
            chk_data(rsp_rdata, exp);
        end
        @(negedge sys_clk);
        chk_bit(rsp_valid, 1'h0);
    endtask

    task automatic idle_check();
        chk_bit(chip_select_primary_n, 1'h1);
        chk_bit(chip_select_secondary, 1'h0);
        chk_bit(data_lines_drive_n, 1'h1);
        chk_bit(req_ready, 1'h0);
        chk_bit(rsp_valid, 1'h0);
    endtask

    task automatic recover();
        int n;
        wait_ready(n);
        chk_bit(n >= RC_CYC, 1'h1);
    endtask

    initial
    begin
        rst = 1'h1;
        req_valid = 1'h0;
        req_write = 1'h0;
        req_addr = 18'h00000;
        req_wdata = 16'h0000;
        req_lane_en = 2'h0;
        supply_retention = 1'h0;
        rows = '{'{1'h1, 18'h00000, 16'h1234, 2'h3, 16'h0000},
            '{1'h0, 18'h00000, 16'h0000, 2'h3, 16'h1234},
            '{1'h1, 18'h3ffff, 16'hffff, 2'h3, 16'h0000},
            '{1'h1, 18'h3ffff, 16'ha5c3, 2'h1, 16'h0000},
            '{1'h0, 18'h3ffff, 16'h0000, 2'h3, 16'hffc3},
            '{1'h1, 18'h3ffff, 16'h7e00, 2'h2, 16'h0000},
            '{1'h0, 18'h3ffff, 16'h0000, 2'h3, 16'h7ec3},
            '{1'h0, 18'h3ffff, 16'h0000, 2'h1, 16'h00c3},
            '{1'h0, 18'h3ffff, 16'h0000, 2'h2, 16'h7e00},
            '{1'h0, 18'h00000, 16'h0000, 2'h0, 16'h0000},
            '{1'h1, 18'h00000, 16'hdead, 2'h0, 16'h0000},
            '{1'h0, 18'h00000, 16'h0000, 2'h3, 16'h1234},
            '{1'h1, 18'h2aaaa, 16'hbeef, 2'h3, 16'h0000},
            '{1'h0, 18'h2aaaa, 16'h0000, 2'h3, 16'hbeef},
            '{1'h0, 18'h00000, 16'h0000, 2'h3, 16'h1234}};
        repeat (4) @(negedge sys_clk);
        idle_check();
        rst = 1'h0;
        recover();
        foreach (rows[i])
            do_req(rows[i].wr, rows[i].a, rows[i].d, rows[i].ln, rows[i].exp);
        send(1'h0, 18'h00000, 16'h0000, 2'h3);
        repeat (5) @(negedge sys_clk);
        rst = 1'h1;
        repeat (4) @(negedge sys_clk);
        idle_check();
        rst = 1'h0;
        recover();
        do_req(1'h0, 18'h00000, 16'h0000, 2'h3, 16'h1234);
        supply_retention = 1'h1;
        repeat (10) @(negedge sys_clk);
        idle_check();
        supply_retention = 1'h0;
        recover();
        do_req(1'h0, 18'h2aaaa, 16'h0000, 2'h3, 16'hbeef);
        do_req(1'h1, 18'h00001, 16'h0f0f, 2'h3, 16'h0000);
        chk_data(rsp_rdata, 16'hbeef);
        chk_bit(rule_err, 1'h0);
        give_verdict();
    end
endmodule
